//--- core/timer_pkg.sv
// Package for the 8-bit timer/counter core: widths, limits, select codes,
// mode encodings and flag positions.
// Assumes every user compiles it first and refers to it by scope.
package timer_pkg;

   // Widths
   localparam int CNT_W      = 8;
   localparam int SEL_W      = 3;
   localparam int PRESCALE_W = 10;
   localparam int FLAG_W     = 2;
   localparam int COM_W      = 2;

   // Count limits and reset values
   localparam logic [CNT_W-1:0] BOTTOM_VALUE  = 8'h00;
   localparam logic [CNT_W-1:0] MAX_VALUE     = 8'hFF;
   localparam logic [CNT_W-1:0] CNT_STEP      = 8'h01;
   localparam logic [CNT_W-1:0] COUNT_RESET   = 8'h00;
   localparam logic [CNT_W-1:0] COMPARE_RESET = 8'h00;
   localparam logic [FLAG_W-1:0] FLAG_RESET   = 2'h0;
   localparam logic [FLAG_W-1:0] MASK_RESET   = 2'h0;
   localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = 10'h000;
   localparam logic [PRESCALE_W-1:0] PRESCALE_STEP  = 10'h001;

   // Clock source select codes
   localparam logic [SEL_W-1:0] SEL_STOP     = 3'h0;
   localparam logic [SEL_W-1:0] SEL_DIV1     = 3'h1;
   localparam logic [SEL_W-1:0] SEL_DIV8     = 3'h2;
   localparam logic [SEL_W-1:0] SEL_DIV64    = 3'h3;
   localparam logic [SEL_W-1:0] SEL_DIV256   = 3'h4;
   localparam logic [SEL_W-1:0] SEL_DIV1024  = 3'h5;
   localparam logic [SEL_W-1:0] SEL_EXT_FALL = 3'h6;
   localparam logic [SEL_W-1:0] SEL_EXT_RISE = 3'h7;

   // Prescaler taps: tick when the masked low bits are all ones
   localparam logic [PRESCALE_W-1:0] TAP_DIV8    = 10'h007;
   localparam logic [PRESCALE_W-1:0] TAP_DIV64   = 10'h03F;
   localparam logic [PRESCALE_W-1:0] TAP_DIV256  = 10'h0FF;
   localparam logic [PRESCALE_W-1:0] TAP_DIV1024 = 10'h3FF;

   // Flag and mask bit positions
   localparam int FLAG_OVF_BIT = 0;
   localparam int FLAG_CMP_BIT = 1;

   // Compare output actions
   localparam logic [COM_W-1:0] COM_OFF    = 2'h0;
   localparam logic [COM_W-1:0] COM_TOGGLE = 2'h1;
   localparam logic [COM_W-1:0] COM_CLEAR  = 2'h2;
   localparam logic [COM_W-1:0] COM_SET    = 2'h3;

   typedef enum logic [1:0] {
      MODE_NORMAL    = 2'h0,
      MODE_PHASE_PWM = 2'h1,
      MODE_CTC       = 2'h2,
      MODE_FAST_PWM  = 2'h3
   } wave_mode_type;

   typedef enum logic {
      DIR_UP   = 1'b0,
      DIR_DOWN = 1'b1
   } dir_state_type;

endpackage

//--- core/timer_tick_if.sv
// Interface between the counter core and its clock select unit.
// Assumes both ends run on the same core clock.
`timescale 1ns/100ps
`default_nettype none

interface timer_tick_if;
   logic [timer_pkg::SEL_W-1:0] sel;
   logic                        ext_pin;
   logic                        tick;

   modport selector (input sel, input ext_pin, output tick);
   modport counter  (output sel, output ext_pin, input tick);
endinterface

`default_nettype wire

//--- core/timer_clock_select.sv
// Clock select unit: prescaler and external edge detector forming the tick.
// Assumes the external count pin is already synchronous to core_clk.
`timescale 1ns/100ps
`default_nettype none

module timer_clock_select (
   input  wire logic           core_clk,
   input  wire logic           resetn,
   timer_tick_if.selector      tick_bus
);

   logic [timer_pkg::PRESCALE_W-1:0] prescale_ff;
   logic                             ext_prev_ff;
   logic                             ext_rise;
   logic                             ext_fall;

   // Free-running prescaler, shared by every divided source
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         prescale_ff <= timer_pkg::PRESCALE_RESET;
      end else begin
         prescale_ff <= prescale_ff + timer_pkg::PRESCALE_STEP;
      end
   end

   // Previous pin level for edge detection
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ext_prev_ff <= 1'b0;
      end else begin
         ext_prev_ff <= tick_bus.ext_pin;
      end
   end

   assign ext_rise = tick_bus.ext_pin & ~ext_prev_ff;
   assign ext_fall = ~tick_bus.ext_pin & ext_prev_ff;

   // Source and edge choice; code zero gives no tick at all
   always_comb begin
      unique case (tick_bus.sel)
         timer_pkg::SEL_STOP:     tick_bus.tick = 1'b0;
         timer_pkg::SEL_DIV1:     tick_bus.tick = 1'b1;
         timer_pkg::SEL_DIV8:     tick_bus.tick = &(prescale_ff | ~timer_pkg::TAP_DIV8);
         timer_pkg::SEL_DIV64:    tick_bus.tick = &(prescale_ff | ~timer_pkg::TAP_DIV64);
         timer_pkg::SEL_DIV256:   tick_bus.tick = &(prescale_ff | ~timer_pkg::TAP_DIV256);
         timer_pkg::SEL_DIV1024:  tick_bus.tick = &(prescale_ff | ~timer_pkg::TAP_DIV1024);
         timer_pkg::SEL_EXT_FALL: tick_bus.tick = ext_fall;
         timer_pkg::SEL_EXT_RISE: tick_bus.tick = ext_rise;
      endcase
   end

   AST_STOP_NO_TICK: assert property (@(posedge core_clk) disable iff (!resetn)
      tick_bus.sel == timer_pkg::SEL_STOP |-> !tick_bus.tick)
      else $error("tick while clock source is stopped");

   AST_EXT_RISE_TICK: assert property (@(posedge core_clk) disable iff (!resetn)
      (tick_bus.sel == timer_pkg::SEL_EXT_RISE && !$past(tick_bus.ext_pin)
       && tick_bus.ext_pin) |-> tick_bus.tick)
      else $error("rising edge on count pin gave no tick");

endmodule

`default_nettype wire

//--- core/timer_counter_8bit_core.sv
// Top of the 8-bit timer/counter: counter, compare unit, flags, masks
// and the compare waveform flip-flop.
// Assumes all inputs are synchronous to core_clk and strobes last one cycle.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Counter and compare registers are eight bits wide.
// - Count from the prescaled core clock or the external count pin.
// - Clock select picks source and edge; its output is the tick.
// - With no source selected the counter does not move.
// - Compare value and counter are compared every cycle.
// - Compare writes pass through a buffer before the active value in the PWM modes; other modes write it directly.
// - Compare result drives a PWM or frequency output pin.
// - A compare match sets the compare flag, which can raise a request.
// - Every timer request shows as a bit of the flag register.
// - Each request is gated by its own mask bit.
// - Two request sources: counter overflow and compare match.
// - Bottom is signalled when the counter becomes zero.
// - Max is signalled when the counter becomes 255.
// - Top is either 255 or the compare value, by mode.
// - A mode clears the counter on compare match.
// - A phase-correct up-down PWM mode is offered.
// - Select code zero stops the timer.
// - A counter write beats any clear or count in that cycle.
// - Compare flag sets at the tick after counter equals compare.
// - Compare flag clears on interrupt taken or a one written.
module timer_counter_8bit_core (
   input  wire logic                           core_clk,
   input  wire logic                           resetn,
   input  wire logic [timer_pkg::SEL_W-1:0]    clock_source_select,
   input  wire logic                           external_count_pin,
   input  wire logic [1:0]                     wave_mode_select,
   input  wire logic [timer_pkg::COM_W-1:0]    compare_out_mode,
   input  wire logic                           force_compare,
   input  wire logic                           count_wr_en,
   input  wire logic [timer_pkg::CNT_W-1:0]    count_wr_data,
   input  wire logic                           compare_wr_en,
   input  wire logic [timer_pkg::CNT_W-1:0]    compare_wr_data,
   input  wire logic                           flag_wr_en,
   input  wire logic [timer_pkg::FLAG_W-1:0]   flag_wr_data,
   input  wire logic                           mask_wr_en,
   input  wire logic [timer_pkg::FLAG_W-1:0]   mask_wr_data,
   input  wire logic [timer_pkg::FLAG_W-1:0]   irq_ack,
   output logic      [timer_pkg::CNT_W-1:0]    timer_count_value,
   output logic      [timer_pkg::CNT_W-1:0]    compare_value_register,
   output logic      [timer_pkg::CNT_W-1:0]    compare_buffer_value,
   output logic      [timer_pkg::FLAG_W-1:0]   timer_flag_register,
   output logic      [timer_pkg::FLAG_W-1:0]   timer_mask_register,
   output logic                                overflow_irq,
   output logic                                compare_irq,
   output logic                                compare_output_pin,
   output logic                                at_bottom,
   output logic                                at_max,
   output logic                                at_top
);

   timer_pkg::wave_mode_type         mode;
   timer_pkg::dir_state_type         dir_ff;
   timer_pkg::dir_state_type         nxt_dir;
   logic [timer_pkg::CNT_W-1:0]      count_ff;
   logic [timer_pkg::CNT_W-1:0]      nxt_count;
   logic [timer_pkg::CNT_W-1:0]      cmp_active_ff;
   logic [timer_pkg::CNT_W-1:0]      cmp_buffer_ff;
   logic [timer_pkg::CNT_W-1:0]      top_value;
   logic [timer_pkg::FLAG_W-1:0]     flags_ff;
   logic [timer_pkg::FLAG_W-1:0]     nxt_flags;
   logic [timer_pkg::FLAG_W-1:0]     flag_set;
   logic [timer_pkg::FLAG_W-1:0]     flag_clr;
   logic [timer_pkg::FLAG_W-1:0]     mask_ff;
   logic                             irq_ovf_ff;
   logic                             irq_cmp_ff;
   logic                             block_ff;
   logic                             wave_ff;
   logic                             bottom_ff;
   logic                             max_ff;
   logic                             top_ff;
   logic                             tick;
   logic                             cmp_equal;
   logic                             cmp_event;
   logic                             ovf_event;
   logic                             pwm_mode;

   // Top of the count sequence for a mode
   function automatic logic [timer_pkg::CNT_W-1:0] top_of(
      input timer_pkg::wave_mode_type m,
      input logic [timer_pkg::CNT_W-1:0] cmp
   );
      top_of = (m == timer_pkg::MODE_CTC) ? cmp : timer_pkg::MAX_VALUE;
   endfunction

   // Pin level after a compare action in the non-PWM modes
   function automatic logic com_action(
      input logic [timer_pkg::COM_W-1:0] com,
      input logic cur
   );
      unique case (com)
         timer_pkg::COM_OFF:    com_action = cur;
         timer_pkg::COM_TOGGLE: com_action = ~cur;
         timer_pkg::COM_CLEAR:  com_action = 1'b0;
         timer_pkg::COM_SET:    com_action = 1'b1;
      endcase
   endfunction

   timer_tick_if tick_bus ();

   assign tick_bus.sel     = clock_source_select;
   assign tick_bus.ext_pin = external_count_pin;
   assign tick            = tick_bus.tick;

   // Tick generation lives in its own unit
   timer_clock_select u_clock_select (
      .core_clk (core_clk),
      .resetn   (resetn),
      .tick_bus (tick_bus.selector)
   );

   assign mode      = timer_pkg::wave_mode_type'(wave_mode_select);
   assign pwm_mode  = (mode == timer_pkg::MODE_PHASE_PWM) || (mode == timer_pkg::MODE_FAST_PWM);
   assign top_value = top_of(mode, cmp_active_ff);

   // Comparator sees the counter every cycle, in every mode
   assign cmp_equal = (count_ff == cmp_active_ff);
   // Match counts at the following tick unless a counter write blocked it
   assign cmp_event = tick && cmp_equal && !block_ff;

   // Overflow: wrap past max, or turn at bottom in phase-correct mode
   always_comb begin
      ovf_event = 1'b0;
      if (tick && !count_wr_en) begin
         if (mode == timer_pkg::MODE_PHASE_PWM) begin
            ovf_event = (dir_ff == timer_pkg::DIR_DOWN) && (count_ff == timer_pkg::BOTTOM_VALUE);
         end else begin
            ovf_event = (count_ff == timer_pkg::MAX_VALUE);
         end
      end
   end

   // Next count and direction; a software write overrides everything
   always_comb begin
      nxt_count = count_ff;
      nxt_dir   = dir_ff;
      if (count_wr_en) begin
         nxt_count = count_wr_data;
      end else if (tick) begin // No tick, no movement
         unique case (mode)
            timer_pkg::MODE_NORMAL, timer_pkg::MODE_FAST_PWM: begin
               nxt_count = count_ff + timer_pkg::CNT_STEP;
            end
            timer_pkg::MODE_CTC: begin
               // Clear on match gives an automatic reload
               if (cmp_equal) begin
                  nxt_count = timer_pkg::BOTTOM_VALUE;
               end else begin
                  nxt_count = count_ff + timer_pkg::CNT_STEP;
               end
            end
            timer_pkg::MODE_PHASE_PWM: begin
               // Up to top, then down to bottom
               unique case (dir_ff)
                  timer_pkg::DIR_UP: begin
                     if (count_ff == top_value) begin
                        nxt_dir   = timer_pkg::DIR_DOWN;
                        nxt_count = count_ff - timer_pkg::CNT_STEP;
                     end else begin
                        nxt_count = count_ff + timer_pkg::CNT_STEP;
                     end
                  end
                  timer_pkg::DIR_DOWN: begin
                     if (count_ff == timer_pkg::BOTTOM_VALUE) begin
                        nxt_dir   = timer_pkg::DIR_UP;
                        nxt_count = count_ff + timer_pkg::CNT_STEP;
                     end else begin
                        nxt_count = count_ff - timer_pkg::CNT_STEP;
                     end
                  end
               endcase
            end
         endcase
      end
   end

   // Counter register
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         count_ff <= timer_pkg::COUNT_RESET;
      end else begin
         count_ff <= nxt_count;
      end
   end

   // Up-down state for the phase-correct mode
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         dir_ff <= timer_pkg::DIR_UP;
      end else if (mode != timer_pkg::MODE_PHASE_PWM) begin
         dir_ff <= timer_pkg::DIR_UP;
      end else begin
         dir_ff <= nxt_dir;
      end
   end

   // A counter write hides any match at the next tick, even when stopped
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         block_ff <= 1'b0;
      end else if (count_wr_en) begin
         block_ff <= 1'b1;
      end else if (tick) begin
         block_ff <= 1'b0;
      end
   end

   // Compare buffer always takes writes
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cmp_buffer_ff <= timer_pkg::COMPARE_RESET;
      end else if (compare_wr_en) begin
         cmp_buffer_ff <= compare_wr_data;
      end
   end

   // Active value: direct in non-PWM modes, at max in PWM modes so no odd pulses
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cmp_active_ff <= timer_pkg::COMPARE_RESET;
      end else if (!pwm_mode && compare_wr_en) begin
         cmp_active_ff <= compare_wr_data;
      end else if (pwm_mode && tick && count_ff == timer_pkg::MAX_VALUE) begin
         cmp_active_ff <= cmp_buffer_ff;
      end
   end

   // Flags: set wins over a clear in the same cycle
   always_comb begin
      flag_set = '0;
      flag_set[timer_pkg::FLAG_OVF_BIT] = ovf_event;
      flag_set[timer_pkg::FLAG_CMP_BIT] = cmp_event;
      flag_clr  = irq_ack | (flag_wr_en ? flag_wr_data : timer_pkg::FLAG_RESET);
      nxt_flags = (flags_ff & ~flag_clr) | flag_set;
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         flags_ff <= timer_pkg::FLAG_RESET;
      end else begin
         flags_ff <= nxt_flags;
      end
   end

   // Mask register
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         mask_ff <= timer_pkg::MASK_RESET;
      end else if (mask_wr_en) begin
         mask_ff <= mask_wr_data;
      end
   end

   // Requests gated one by one; one cycle behind the flag
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         irq_ovf_ff <= 1'b0;
         irq_cmp_ff <= 1'b0;
      end else begin
         irq_ovf_ff <= flags_ff[timer_pkg::FLAG_OVF_BIT] & mask_ff[timer_pkg::FLAG_OVF_BIT];
         irq_cmp_ff <= flags_ff[timer_pkg::FLAG_CMP_BIT] & mask_ff[timer_pkg::FLAG_CMP_BIT];
      end
   end

   // Waveform flip-flop; force acts only outside PWM and sets no flag
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wave_ff <= 1'b0;
      end else if (!pwm_mode) begin
         if (force_compare || cmp_event) begin
            wave_ff <= com_action(compare_out_mode, wave_ff);
         end
      end else if (compare_out_mode[1] && tick && !count_wr_en) begin
         // COM_SET inverts the sense of COM_CLEAR
         if (cmp_event) begin
            wave_ff <= compare_out_mode[0] ^ (dir_ff == timer_pkg::DIR_DOWN);
         end else if (mode == timer_pkg::MODE_FAST_PWM && count_ff == timer_pkg::MAX_VALUE) begin
            wave_ff <= ~compare_out_mode[0];
         end
      end
   end

   // Extreme-value indicators follow the counter's new value
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         bottom_ff <= 1'b1;
         max_ff    <= 1'b0;
         top_ff    <= 1'b0;
      end else begin
         bottom_ff <= (nxt_count == timer_pkg::BOTTOM_VALUE);
         max_ff    <= (nxt_count == timer_pkg::MAX_VALUE);
         top_ff    <= (nxt_count == top_value);
      end
   end

   assign timer_count_value      = count_ff;
   assign compare_value_register = cmp_active_ff;
   assign compare_buffer_value   = cmp_buffer_ff;
   assign timer_flag_register    = flags_ff;
   assign timer_mask_register    = mask_ff;
   assign overflow_irq           = irq_ovf_ff;
   assign compare_irq            = irq_cmp_ff;
   assign compare_output_pin     = wave_ff;
   assign at_bottom              = bottom_ff;
   assign at_max                 = max_ff;
   assign at_top                 = top_ff;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   AST_STOPPED_HOLDS: assert property (
      (clock_source_select == timer_pkg::SEL_STOP && !count_wr_en) |=> $stable(count_ff))
      else $error("counter moved with no clock source");

   AST_WRITE_WINS: assert property (
      count_wr_en |=> count_ff == $past(count_wr_data))
      else $error("counter write lost to count or clear");

   AST_CMP_FLAG_SET: assert property (
      (tick && count_ff == cmp_active_ff && !block_ff) |=> flags_ff[timer_pkg::FLAG_CMP_BIT])
      else $error("compare flag not set after match");

   AST_WRITE_BLOCKS_MATCH: assert property (
      (count_wr_en ##1 (tick && !count_wr_en && !flags_ff[timer_pkg::FLAG_CMP_BIT]
       && cmp_equal)) |=> !flags_ff[timer_pkg::FLAG_CMP_BIT])
      else $error("match not blocked after counter write");

   AST_FLAG_CLEAR: assert property (
      (irq_ack[timer_pkg::FLAG_CMP_BIT] && !cmp_event) |=> !flags_ff[timer_pkg::FLAG_CMP_BIT])
      else $error("compare flag not cleared on acknowledge");

   AST_MASK_GATES: assert property (
      (!mask_ff[timer_pkg::FLAG_OVF_BIT] ##1 !mask_ff[timer_pkg::FLAG_OVF_BIT]) |-> !overflow_irq)
      else $error("masked overflow raised a request");

   AST_IRQ_FOLLOWS: assert property (
      (flags_ff[timer_pkg::FLAG_CMP_BIT] && mask_ff[timer_pkg::FLAG_CMP_BIT]) |=> compare_irq)
      else $error("enabled compare flag raised no request");

   AST_BOTTOM_SEEN: assert property (
      at_bottom == (count_ff == timer_pkg::BOTTOM_VALUE))
      else $error("bottom indicator disagrees with counter");

   AST_MAX_SEEN: assert property (
      at_max == (count_ff == timer_pkg::MAX_VALUE))
      else $error("max indicator disagrees with counter");

   AST_CTC_CLEAR: assert property (
      (mode == timer_pkg::MODE_CTC && tick && cmp_equal && !count_wr_en)
      |=> count_ff == timer_pkg::BOTTOM_VALUE)
      else $error("counter not cleared on match in clear mode");

   AST_OVERFLOW: assert property (
      (mode == timer_pkg::MODE_NORMAL && tick && !count_wr_en
       && count_ff == timer_pkg::MAX_VALUE)
      |=> (flags_ff[timer_pkg::FLAG_OVF_BIT] && count_ff == timer_pkg::BOTTOM_VALUE))
      else $error("wrap past max gave no overflow");

   AST_DIRECT_COMPARE: assert property (
      (!pwm_mode && compare_wr_en) |=> cmp_active_ff == $past(compare_wr_data))
      else $error("direct compare write not applied");

endmodule

`default_nettype wire

//--- sim/timer_counter_8bit_core_bench.sv
// Self-checking bench for the 8-bit timer/counter core, ports driven directly.
// Assumes the core package, tick interface and design files are compiled first.
`timescale 1ns/100ps
`default_nettype none

module timer_counter_8bit_core_bench;
   typedef struct packed {logic [2:0] k; logic [7:0] v;} note_type;
   logic       core_clk, resetn, external_count_pin, force_compare, pin_v;
   logic       count_wr_en, compare_wr_en, flag_wr_en, mask_wr_en;
   logic       compare_output_pin, overflow_irq, compare_irq, at_bottom, at_max, at_top;
   logic [2:0] clock_source_select;
   logic [1:0] wave_mode_select, compare_out_mode, flag_wr_data, mask_wr_data, irq_ack;
   logic [1:0] timer_flag_register, timer_mask_register;
   logic [7:0] count_wr_data, compare_wr_data, timer_count_value, rv;
   logic [7:0] compare_value_register, compare_buffer_value;
   logic [31:0] seed;
   int         err_total, num_checks, ex, i;
   note_type   exp_q[$];
   note_type   cur;

   timer_counter_8bit_core dut (.*);

   // Free running 250 MHz core clock
   always #2 core_clk = ~core_clk;

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction

   task automatic results();
      if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] want);
      num_checks++;
      if (got !== want) begin
         err_total++;
         $display("ERROR %0t: byte %h, expected %h", $time, got, want);
      end
   endtask

   task automatic cmp_bits(input logic [2:0] got, input logic [2:0] want);
      num_checks++;
      if (got !== want) begin
         err_total++;
         $display("ERROR %0t: bits %b, expected %b", $time, got, want);
      end
   endtask

   // A note taken at an edge describes the state just after that edge
   task automatic note(input logic [2:0] k, input logic [7:0] v);
      exp_q.push_back({k, v});
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // Strobes last one cycle only
   task automatic idle();
      count_wr_en   <= 1'b0;
      compare_wr_en <= 1'b0;
      flag_wr_en    <= 1'b0;
      mask_wr_en    <= 1'b0;
      force_compare <= 1'b0;
      irq_ack       <= 2'h0;
   endtask

   // Bounded wait until the counter shows v; returns on the following edge
   task automatic wait_cnt(input logic [7:0] v);
      for (i = 0; i < 3000; i++) begin
         @(negedge core_clk);
         if (timer_count_value === v) break;
      end
      if (i == 3000) begin
         err_total++;
         $display("ERROR %0t: counter never reached %h", $time, v);
         results();
      end
      @(posedge core_clk);
   endtask

   // Compare at the falling edge, well away from input changes
   always @(negedge core_clk) begin
      while (exp_q.size() > 0) begin
         cur = exp_q.pop_front();
         case (cur.k)
            3'h0: cmp_byte(timer_count_value, cur.v);
            3'h1: cmp_byte(compare_value_register, cur.v);
            3'h2: cmp_byte(compare_buffer_value, cur.v);
            3'h3: cmp_bits({1'b0, timer_flag_register}, cur.v[2:0]);
            3'h4: cmp_bits({1'b0, timer_mask_register}, cur.v[2:0]);
            3'h5: cmp_bits({1'b0, overflow_irq, compare_irq}, cur.v[2:0]);
            3'h6: cmp_bits({at_bottom, at_max, at_top}, cur.v[2:0]);
            default: cmp_bits({2'b00, compare_output_pin}, cur.v[2:0]);
         endcase
      end
   end

   initial begin
      core_clk = 1'b0;
      resetn = 1'b0;
      seed = 32'h0000_bb5c;
      {count_wr_en, compare_wr_en, flag_wr_en, mask_wr_en, force_compare} = '0;
      {external_count_pin, pin_v, clock_source_select, wave_mode_select} = '0;
      {compare_out_mode, flag_wr_data, mask_wr_data, irq_ack} = '0;
      {count_wr_data, compare_wr_data} = '0;
      step(3);
      resetn <= 1'b1;
      note(0, 8'h00); note(1, 8'h00); note(2, 8'h00); note(3, 8'h00);
      note(4, 8'h00); note(5, 8'h00); note(6, 8'h04);
      // Compare match walk with both masks open
      mask_wr_en <= 1'b1; mask_wr_data <= 2'h3; compare_wr_en <= 1'b1;
      compare_wr_data <= 8'h02; count_wr_en <= 1'b1; count_wr_data <= 8'h01;
      step(1); idle(); clock_source_select <= 3'h1;
      note(0, 8'h01); note(1, 8'h02); note(4, 8'h03);
      wait_cnt(8'h02);
      note(0, 8'h03); note(3, 8'h02);
      step(1); note(5, 8'h01);
      // Stop, then a random counter value must hold still
      seed = xs(seed); rv = seed[7:0];
      clock_source_select <= 3'h0; count_wr_en <= 1'b1; count_wr_data <= rv;
      step(1); idle(); note(0, rv);
      step(5); note(0, rv);
      // Forced toggle while stopped in normal mode; must set no flag
      flag_wr_en <= 1'b1; flag_wr_data <= 2'h2; force_compare <= 1'b1; compare_out_mode <= 2'h1;
      step(1); idle(); note(3, 8'h00); note(7, 8'h01);
      step(1); note(5, 8'h00);
      // Overflow from max, cleared by the interrupt acknowledge
      count_wr_en <= 1'b1; count_wr_data <= 8'hff; compare_wr_en <= 1'b1;
      compare_wr_data <= 8'h80;
      step(1); idle(); note(0, 8'hff); note(1, 8'h80); note(6, 8'h03);
      clock_source_select <= 3'h1;
      wait_cnt(8'h00);
      note(3, 8'h01); note(5, 8'h02);
      irq_ack <= 2'h1; clock_source_select <= 3'h0;
      step(1); idle(); note(3, 8'h00);
      // Divide by eight: one step every eight edges
      count_wr_en <= 1'b1; count_wr_data <= 8'h00;
      step(1); idle(); clock_source_select <= 3'h2;
      wait_cnt(8'h01); note(0, 8'h01);
      step(6); note(0, 8'h01);
      step(1); note(0, 8'h02);
      // External pin: falling edges, then rising edges
      clock_source_select <= 3'h0; count_wr_en <= 1'b1; count_wr_data <= 8'h00;
      step(1); idle(); ex = 0;
      for (int s = 6; s < 8; s++) begin
         clock_source_select <= s[2:0];
         step(1);
         repeat (2) begin
            pin_v = ~pin_v;
            external_count_pin <= pin_v;
            step(4);
            ex += int'(pin_v == (s == 7));
            note(0, ex[7:0]);
         end
      end
      // Clear on match, top at the compare value, write priority
      clock_source_select <= 3'h0; wave_mode_select <= 2'h2; count_wr_en <= 1'b1;
      count_wr_data <= 8'h00; compare_wr_en <= 1'b1; compare_wr_data <= 8'h03;
      step(1); idle(); clock_source_select <= 3'h1;
      wait_cnt(8'h02); note(0, 8'h03); note(6, 8'h01);
      step(1); note(0, 8'h00); note(6, 8'h04);
      note(7, 8'h00);
      count_wr_en <= 1'b1; count_wr_data <= 8'h02;
      step(1); idle(); note(0, 8'h02);
      step(1); note(0, 8'h03);
      // Phase-correct mode: buffered compare, turn at max
      clock_source_select <= 3'h0; wave_mode_select <= 2'h1; count_wr_en <= 1'b1;
      count_wr_data <= 8'hf0; compare_wr_en <= 1'b1; compare_wr_data <= 8'h40;
      step(1); idle(); note(2, 8'h40); note(1, 8'h03);
      clock_source_select <= 3'h1;
      wait_cnt(8'hff); note(0, 8'hfe); note(1, 8'h40);
      step(1); note(0, 8'hfd);
      step(2);
      results();
   end
endmodule

`default_nettype wire
